// *** hw/mrcb_pkg.sv ***
// What this block does
// - reset input stops work, clears status bits
// - reset leaves translation entries and control intact
// - reset/abort output held active during reset
// - translate strobe low five ticks after reset
// - bus width strap caught at reset release
// - processor gives address, status with strobe
// - physical address out with valid pulse
// - status lines decoded, line zero lsb
// - fetch, data and address-read codes classified
// - read-modify-write read counts as write
// - other strobed codes count as data
// - slave codes recognised with slave strobe
// - direction sampled, driven in own cycles
// - privilege picks space and checks protection
// - float asserted while reloading or updating
// - abort is exactly one low tick
// - own transfers low word only, 16-bit
// - phase one rising edge advances state
// - page number translated, offset passed through
// - first state latches address and lines
// - no valid pulse on aborted access
package mrcb_pkg;
  // register byte offsets
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_MSR      = 5'h04;
  localparam logic [4:0] REG_TLB_SEL  = 5'h08;
  localparam logic [4:0] REG_TLB_TAG  = 5'h0C;
  localparam logic [4:0] REG_TLB_DATA = 5'h10;
  // control fields
  localparam int CTRL_XLATE_EN = 0;
  localparam int CTRL_BASE_LO  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status fields
  localparam int MSR_PROT  = 0;
  localparam int MSR_MISS  = 1;
  localparam int MSR_WRITE = 2;
  localparam int MSR_USER  = 3;
  localparam int MSR_BUS16 = 4;
  localparam int MSR_SLAVE = 5;
  localparam int MSR_W     = 6;
  // entry fields
  localparam int TAG_USER  = 15;
  localparam int TAG_VALID = 16;
  localparam int DAT_PL    = 16;
  localparam int DAT_MOD   = 18;
  // geometry
  localparam int ENTRIES   = 4;
  localparam int PAGE_W    = 15;
  localparam int OFFS_W    = 9;
  localparam int FRAME_W   = 16;
  localparam int VADDR_W   = 24;
  localparam int PADDR_W   = 25;
  // timing in ticks of phase one
  localparam logic [2:0] AT_HOLD_TICKS = 3'h5;
  localparam logic [1:0] FLOAT_TICKS   = 2'h2;
  // status codes
  localparam logic [3:0] ST_FETCH_SEQ = 4'h8;
  localparam logic [3:0] ST_FETCH_NSQ = 4'h9;
  localparam logic [3:0] ST_DATA      = 4'hA;
  localparam logic [3:0] ST_RMW       = 4'hB;
  localparam logic [3:0] ST_EADDR     = 4'hC;
  localparam logic [3:0] ST_SLV_OPND  = 4'hD;
  localparam logic [3:0] ST_SLV_STAT  = 4'hE;
  localparam logic [3:0] ST_SLV_ID    = 4'hF;
  // protection levels
  localparam logic [1:0] PL_USER_RD = 2'h2;
  localparam logic [1:0] PL_USER_WR = 2'h3;
  localparam logic [1:0] PL_SUP_WR  = 2'h1;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_FETCH, CLS_DATA, CLS_EADDR, CLS_RMW, CLS_SLAVE
  } mrcb_cls_e;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_XLATE = 3'b001,
    S_PAV   = 3'b011,
    S_FLOAT = 3'b010,
    S_ABORT = 3'b110
  } mrcb_state_e;
endpackage

// *** hw/mrcb_status_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module mrcb_status_decode (
  // processor cycle lines
  input  wire logic [3:0]         statusCode,
  input  wire logic               addrStrobeN,
  input  wire logic               slaveStrobeN,
  input  wire logic               dirWrite,
  // classification
  output mrcb_pkg::mrcb_cls_e     cls,
  output logic                    accWrite
);
  import mrcb_pkg::*;

  // classify the cycle; bit zero of the code is its lsb
  always_comb begin
    cls      = CLS_NONE;
    accWrite = dirWrite;
    unique case (statusCode)
      ST_FETCH_SEQ, ST_FETCH_NSQ: if (!addrStrobeN) cls = CLS_FETCH;
      ST_DATA:  if (!addrStrobeN) cls = CLS_DATA;
      ST_EADDR: if (!addrStrobeN) cls = CLS_EADDR;
      ST_RMW: begin
        // a read, but protection sees it as a write
        if (!addrStrobeN) cls = CLS_RMW;
        accWrite = 1'b1;
      end
      ST_SLV_OPND, ST_SLV_STAT, ST_SLV_ID: begin
        // slave traffic is outside translation
        if (!slaveStrobeN) cls = CLS_SLAVE;
        else if (!addrStrobeN) cls = CLS_DATA;
      end
      default: if (!addrStrobeN) cls = CLS_DATA;
    endcase
  end
endmodule
`default_nettype wire

// *** hw/mrcb_top.sv ***
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mrcb_top (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // timing unit side
  input  wire logic                clockPhaseOne,
  input  wire logic                resetInN,
  input  wire logic                busWidthSelect,
  // processor side
  input  wire logic [23:0]         cpuAddrIn,
  input  wire logic                addrStrobeN,
  input  wire logic [3:0]          cycleStatusCode,
  input  wire logic                userMode,
  input  wire logic                dataDirectionNIn,
  output logic                     dataDirectionNOut,
  output logic                     dataDirectionOeN,
  input  wire logic                translateModeSlaveStrobeNIn,
  output logic                     translateModeSlaveStrobeNOut,
  output logic                     translateModeSlaveStrobeOeN,
  output logic                     cpuResetAbortN,
  output logic                     busFloatRequestN,
  // physical address side
  output logic [24:0]              physAddr,
  output logic                     physAddrOeN,
  output logic                     physAddrValidN,
  // avalon-mm slave
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest
);
  import mrcb_pkg::*;

  // software state
  logic [31:0]        ctrl, next_ctrl;           // control
  logic [MSR_W-1:0]   mm_status_register, next_msr;             // status
  logic [1:0]         tlbSel, next_tlbSel;       // entry index
  logic [16:0]        tlbTag [ENTRIES];          // valid, space, page
  logic [18:0]        tlbDat [ENTRIES];          // mod, level, frame
  logic [16:0]        next_tlbTag [ENTRIES];
  logic [18:0]        next_tlbDat [ENTRIES];
  logic [31:0]        next_readdata;
  logic               next_waitrequest;
  // cycle state
  mrcb_state_e        state, next_state;
  logic               phaseOnePrev, resetPrev;   // edge helpers
  logic [2:0]         atCount, next_atCount;     // translate strobe hold
  logic [1:0]         fltCount, next_fltCount;   // float length
  logic [23:0]        vaddr, next_vaddr;         // latched virtual address
  logic               accWr, next_accWr;
  logic               accUser, next_accUser;
  logic               hitMiss, next_hitMiss;     // float ends in abort
  logic [1:0]         hitIdx, next_hitIdx;
  logic               busIs16, next_busIs16;     // strap
  // registered pins
  logic               next_abtN, next_fltN, next_pavN, next_paOeN;
  logic               next_ddOut, next_ddOeN, next_atOut, next_atOeN;
  logic [24:0]        next_pa;
  // decode
  mrcb_cls_e          cls;
  logic               clsWrite;
  logic               tick, resetRise;
  logic [ENTRIES-1:0] hitVec;
  logic               hit, allowed;
  logic [1:0]         hitSel;
  logic               wrAck;

  // one state step per rising edge of phase one
  assign tick      = clockPhaseOne & ~phaseOnePrev;
  assign resetRise = resetInN & ~resetPrev;
  assign wrAck     = avs_write & ~avs_waitrequest;

  mrcb_status_decode u_decode (
    .statusCode   (cycleStatusCode),
    .addrStrobeN  (addrStrobeN),
    .slaveStrobeN (translateModeSlaveStrobeNIn),
    .dirWrite     (dataDirectionNIn),
    .cls          (cls),
    .accWrite     (clsWrite)
  );

  // associative compare, one comparator per entry
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_cmp
      // space bit follows privilege of the access
      assign hitVec[gi] = tlbTag[gi][TAG_VALID] && (tlbTag[gi][TAG_USER] == accUser)
                          && (tlbTag[gi][PAGE_W-1:0] == vaddr[VADDR_W-1:OFFS_W]);
    end
  endgenerate

  // priority pick of the matching entry
  always_comb begin
    hitSel = 2'h0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hitVec[i]) hitSel = i[1:0];
    end
  end
  assign hit = |hitVec;

  // level check against mode and direction
  always_comb begin
    logic [1:0] pl;
    pl = tlbDat[hitSel][DAT_PL+1:DAT_PL];
    if (accUser) allowed = accWr ? (pl == PL_USER_WR) : (pl >= PL_USER_RD);
    else         allowed = accWr ? (pl >= PL_SUP_WR) : 1'b1;
  end

  // register bus next values; one wait cycle per access
  always_comb begin
    next_ctrl        = ctrl;
    next_tlbSel      = tlbSel;
    next_tlbTag      = tlbTag;
    next_tlbDat      = tlbDat;
    next_readdata    = avs_readdata;
    next_waitrequest = 1'b1;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      unique case (avs_address)
        REG_CTRL:     next_readdata = ctrl;
        REG_MSR:      next_readdata = {{(32-MSR_W){1'b0}}, mm_status_register};
        REG_TLB_SEL:  next_readdata = {30'h0, tlbSel};
        REG_TLB_TAG:  next_readdata = {15'h0, tlbTag[tlbSel]};
        REG_TLB_DATA: next_readdata = {13'h0, tlbDat[tlbSel]};
        default:      next_readdata = 32'h0;  // unmapped reads zero
      endcase
    end
    if (wrAck) begin
      unique case (avs_address)
        REG_CTRL:     next_ctrl = avs_writedata;
        REG_TLB_SEL:  next_tlbSel = avs_writedata[1:0];
        REG_TLB_TAG:  next_tlbTag[tlbSel] = avs_writedata[16:0];
        REG_TLB_DATA: next_tlbDat[tlbSel] = avs_writedata[18:0];
        default: ;                            // status and unmapped
      endcase
    end
    // first write to a clean page marks it modified
    if (tick && state == S_FLOAT && fltCount == 2'h1 && !hitMiss) begin
      next_tlbDat[hitIdx][DAT_MOD] = 1'b1;
    end
  end

  // register bus flops; the reset input touches none of these
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl            <= CTRL_RESET;
      tlbSel          <= 2'h0;
      avs_readdata    <= 32'h0;
      avs_waitrequest <= 1'b1;
      for (int i = 0; i < ENTRIES; i++) begin
        tlbTag[i] <= 17'h0;
        tlbDat[i] <= 19'h0;
      end
    end else begin
      ctrl            <= next_ctrl;
      tlbSel          <= next_tlbSel;
      tlbTag          <= next_tlbTag;
      tlbDat          <= next_tlbDat;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // cycle sequencer and pins, next values
  always_comb begin
    next_state    = state;
    next_atCount  = atCount;
    next_fltCount = fltCount;
    next_vaddr    = vaddr;
    next_accWr    = accWr;
    next_accUser  = accUser;
    next_hitMiss  = hitMiss;
    next_hitIdx   = hitIdx;
    next_busIs16  = busIs16;
    next_msr      = mm_status_register;
    next_pavN     = physAddrValidN;
    next_fltN     = busFloatRequestN;
    next_pa       = physAddr;
    next_paOeN    = physAddrOeN;
    next_ddOut    = dataDirectionNOut;
    next_ddOeN    = dataDirectionOeN;
    // software clears status with ones; hardware set wins below
    if (wrAck && avs_address == REG_MSR) begin
      next_msr = mm_status_register & ~avs_writedata[MSR_W-1:0];
      next_msr[MSR_BUS16] = mm_status_register[MSR_BUS16];
    end
    if (resetRise) begin
      next_busIs16 = busWidthSelect;
      next_msr[MSR_BUS16] = busWidthSelect;
      next_atCount = AT_HOLD_TICKS;
    end else if (tick && atCount != 3'h0) begin
      next_atCount = atCount - 3'h1;
    end
    if (tick) begin
      unique case (state)
        S_IDLE: begin
          if (cls == CLS_SLAVE) next_msr[MSR_SLAVE] = 1'b1;
          if (!addrStrobeN && cls != CLS_SLAVE && atCount == 3'h0) begin
            next_vaddr   = cpuAddrIn;
            next_accWr   = clsWrite;
            next_accUser = userMode;
            next_state   = S_XLATE;
          end
        end
        S_XLATE: begin
          next_hitIdx = hitSel;
          if (!ctrl[CTRL_XLATE_EN]) begin
            // translation off: address passes straight through
            next_pa    = {1'b0, vaddr};
            next_paOeN = 1'b0;
            next_pavN  = 1'b0;
            next_state = S_PAV;
          end else if (hit && !allowed) begin
            next_msr[MSR_PROT]  = 1'b1;
            next_msr[MSR_WRITE] = accWr;
            next_msr[MSR_USER]  = accUser;
            next_state = S_ABORT;
          end else if (!hit || (accWr && !tlbDat[hitSel][DAT_MOD])) begin
            // seize the bus to reload or update the entry
            next_hitMiss  = !hit;
            next_fltN     = 1'b0;
            next_fltCount = FLOAT_TICKS;
            // own cycles: low word of the table entry only
            next_pa    = {ctrl[CTRL_BASE_LO +: 8], vaddr[VADDR_W-1:OFFS_W], 2'b00};
            next_paOeN = 1'b0;
            next_ddOut = hit;              // write only to set the modified bit
            next_ddOeN = 1'b0;
            next_state = S_FLOAT;
          end else begin
            next_pa    = {tlbDat[hitSel][FRAME_W-1:0], vaddr[OFFS_W-1:0]};
            next_paOeN = 1'b0;
            next_pavN  = 1'b0;
            next_state = S_PAV;
          end
        end
        S_FLOAT: begin
          next_fltCount = fltCount - 2'h1;
          if (fltCount == 2'h1) begin
            next_fltN  = 1'b1;
            next_ddOeN = 1'b1;
            if (hitMiss) begin
              next_msr[MSR_MISS]  = 1'b1;
              next_msr[MSR_WRITE] = accWr;
              next_msr[MSR_USER]  = accUser;
              next_paOeN = 1'b1;
              next_state = S_ABORT;
            end else begin
              next_pa    = {tlbDat[hitIdx][FRAME_W-1:0], vaddr[OFFS_W-1:0]};
              next_pavN  = 1'b0;
              next_state = S_PAV;
            end
          end
        end
        S_PAV: begin
          next_pavN  = 1'b1;
          next_paOeN = 1'b1;
          next_state = S_IDLE;
        end
        S_ABORT: next_state = S_IDLE;
      endcase
    end
    // abort pin: low through reset or for the single abort tick
    next_abtN = resetInN && (next_state != S_ABORT);
    next_atOeN = (next_atCount == 3'h0);
    next_atOut = 1'b0;
    if (!resetInN) begin
      // stop all work; only status bits are cleared
      next_state    = S_IDLE;
      next_fltN     = 1'b1;
      next_pavN     = 1'b1;
      next_paOeN    = 1'b1;
      next_ddOeN    = 1'b1;
      next_fltCount = 2'h0;
      next_msr      = {MSR_W{1'b0}};
      next_msr[MSR_BUS16] = busIs16;
    end
  end

  // sequencer flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= S_IDLE;  phaseOnePrev <= 1'b0;  resetPrev <= 1'b0;
      atCount <= 3'h0;  fltCount <= 2'h0;  vaddr <= 24'h0;
      accWr <= 1'b0;  accUser <= 1'b0;  hitMiss <= 1'b0;  hitIdx <= 2'h0;
      busIs16 <= 1'b0;  mm_status_register <= {MSR_W{1'b0}};
      cpuResetAbortN <= 1'b0;  busFloatRequestN <= 1'b1;  physAddrValidN <= 1'b1;
      physAddr <= 25'h0;  physAddrOeN <= 1'b1;
      dataDirectionNOut <= 1'b0;  dataDirectionOeN <= 1'b1;
      translateModeSlaveStrobeNOut <= 1'b1;  translateModeSlaveStrobeOeN <= 1'b1;
    end else begin
      state <= next_state;  phaseOnePrev <= clockPhaseOne;  resetPrev <= resetInN;
      atCount <= next_atCount;  fltCount <= next_fltCount;  vaddr <= next_vaddr;
      accWr <= next_accWr;  accUser <= next_accUser;  hitMiss <= next_hitMiss;
      hitIdx <= next_hitIdx;  busIs16 <= next_busIs16;  mm_status_register <= next_msr;
      cpuResetAbortN <= next_abtN;  busFloatRequestN <= next_fltN;
      physAddrValidN <= next_pavN;  physAddr <= next_pa;  physAddrOeN <= next_paOeN;
      dataDirectionNOut <= next_ddOut;  dataDirectionOeN <= next_ddOeN;
      translateModeSlaveStrobeNOut <= next_atOut;  translateModeSlaveStrobeOeN <= next_atOeN;
    end
  end

  // checks
  sequence abortTick_s;
    state == S_ABORT && tick && resetInN;
  endsequence
  sequence releaseSeen_s;
    resetInN && !resetPrev;
  endsequence

  abort_in_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    !resetInN |=> !cpuResetAbortN) else $error("abort output not active in reset");
  abort_one_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
    abortTick_s |=> cpuResetAbortN) else $error("abort longer than one tick");
  abort_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (resetInN && $past(resetInN) && state != S_ABORT) |-> cpuResetAbortN)
    else $error("spurious abort low");
  no_pav_abort_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cpuResetAbortN |-> physAddrValidN) else $error("valid pulse with abort");
  at_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    releaseSeen_s |=> atCount == AT_HOLD_TICKS ##1 !translateModeSlaveStrobeOeN)
    else $error("translate strobe hold not started");
  strap_a: assert property (@(posedge ref_clk) disable iff (rst)
    releaseSeen_s |=> busIs16 == $past(busWidthSelect)) else $error("strap not caught");
  pav_one_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == S_PAV && tick && resetInN) |=> physAddrValidN) else $error("valid pulse too long");
  float_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
    !busFloatRequestN |-> !dataDirectionOeN) else $error("direction not driven in float");
  keep_tlb_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!resetInN && !avs_write) |=> $stable(tlbTag[0]) && $stable(ctrl)) else $error("reset changed entries");
  latch_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == S_IDLE && tick && !addrStrobeN && cls != CLS_SLAVE && atCount == 3'h0 && resetInN)
    |=> vaddr == $past(cpuAddrIn) && state == S_XLATE) else $error("virtual address not latched");
  own_low_word_a: assert property (@(posedge ref_clk) disable iff (rst)
    !busFloatRequestN |-> physAddr[1:0] == 2'b00) else $error("upper word touched");
endmodule
`default_nettype wire

// *** verif/mrcb_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// far side: timing unit phase clock and reset, processor address strobe
module mrcb_host_model (
  // clock
  input  wire logic       ref_clk,
  // bench requests
  input  wire logic       resetReq,
  input  wire logic       cycleReq,
  // device pins
  input  wire logic       busWidthSelect,
  input  wire logic       physAddrValidN,
  input  wire logic       busFloatRequestN,
  input  wire logic [1:0] physAddrLow,
  output logic            clockPhaseOne,
  output logic            resetInN,
  output logic            addrStrobeN,
  // system side: bus strobe and upper half buffer gate
  output logic            busStrobeN,
  output logic            upperBufEnN
);
  logic [1:0] div    = 2'h0; // four clocks per phase-one period
  logic [8:0] rstCnt = 9'h0; // clocks spent in reset
  logic       armed  = 1'b0; // strobe waits for next period start

  // one behavioural process so every output has a value at time zero
  initial begin
    clockPhaseOne = 1'b0;
    resetInN = 1'b0;
    addrStrobeN = 1'b1;
    busStrobeN = 1'b1;
    upperBufEnN = 1'b1;
    forever begin
      @(posedge ref_clk);
      div <= div + 2'h1;
      // bus strobe one clock behind the valid pulse; ready never stretches here
      busStrobeN <= physAddrValidN;
      // 32-bit system: open the upper half buffer when an own cycle hits word two
      upperBufEnN <= busWidthSelect || busFloatRequestN || physAddrLow != 2'b10;
      clockPhaseOne <= div[1];
      if (resetReq) begin
        resetInN <= 1'b0;
        rstCnt <= 9'h0;
      end else if (!resetInN) begin
        rstCnt <= rstCnt + 9'h1;
        // 64 periods done, phase one high now and next clock
        if (rstCnt[8] && clockPhaseOne && div[1]) resetInN <= 1'b1;
      end
      // strobe low for exactly one whole period around a tick
      if (div == 2'h1) begin
        addrStrobeN <= !armed;
        armed <= 1'b0;
      end
      if (cycleReq) armed <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verif/mrcb_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module mrcb_top_tb;
  import mrcb_pkg::*;
  localparam int TICK = 4; // clocks per phase-one period
  // device inputs and outputs
  logic ref_clk, rst, busWidthSelect, userMode, dataDirectionNIn, translateModeSlaveStrobeNIn;
  logic [23:0] cpuAddrIn;
  logic [3:0]  cycleStatusCode;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, resetReq, cycleReq;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        clockPhaseOne, resetInN, addrStrobeN, dataDirectionNOut, dataDirectionOeN;
  logic        translateModeSlaveStrobeNOut, translateModeSlaveStrobeOeN, cpuResetAbortN, busFloatRequestN;
  logic [24:0] physAddr, paSeen;
  logic        physAddrOeN, physAddrValidN, busStrobeN, upperBufEnN;
  logic [26:0] fltSeen;
  int          nStrobe, nUpper;
  int          n_errors = 0;
  int          tests_run = 0;
  int          nValid, nAbort, nFloat, k;
  logic [3:0]  okCodes [6] = '{ST_FETCH_SEQ, ST_FETCH_NSQ, ST_DATA, ST_EADDR, 4'h4, 4'h6};

  mrcb_host_model host (.ref_clk, .resetReq, .cycleReq, .busWidthSelect, .physAddrValidN, .busFloatRequestN,
    .physAddrLow (physAddr[1:0]), .clockPhaseOne, .resetInN, .addrStrobeN, .busStrobeN, .upperBufEnN);
  mrcb_top dut (.ref_clk, .rst, .clockPhaseOne, .resetInN, .busWidthSelect, .cpuAddrIn, .addrStrobeN,
    .cycleStatusCode, .userMode, .dataDirectionNIn, .dataDirectionNOut, .dataDirectionOeN,
    .translateModeSlaveStrobeNIn, .translateModeSlaveStrobeNOut, .translateModeSlaveStrobeOeN,
    .cpuResetAbortN, .busFloatRequestN, .physAddr, .physAddrOeN, .physAddrValidN, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) n_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // reset pulse, strap caught, translate strobe, status cleared, rest kept
  task automatic resetTest(input logic sel);
    busWidthSelect <= sel;
    resetReq <= 1'b1;
    @(posedge ref_clk);
    resetReq <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(cpuResetAbortN, 1'b0);
    k = 0;
    while (resetInN !== 1'b1 && k < 400) begin @(posedge ref_clk); k++; end
    if (k >= 400) n_errors++;
    repeat (2) @(posedge ref_clk);
    check({translateModeSlaveStrobeOeN, translateModeSlaveStrobeNOut}, 2'b00);
    k = 0;
    while (translateModeSlaveStrobeOeN === 1'b0 && k < 60) begin @(posedge ref_clk); k++; end
    check(k >= 5 * TICK - 3 && k <= 5 * TICK + 3, 1'b1);
    check(cpuResetAbortN, 1'b1);
    bus(1'b0, REG_MSR, 32'h0);
    check(rd, {27'h0, sel, 4'h0});
    bus(1'b0, REG_TLB_SEL, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, REG_TLB_TAG, 32'h0);
    check(rd, 32'h0001_8321);
  endtask

  // one processor cycle; counts low clocks of each answer line
  task automatic cyc(input logic [23:0] va, input logic [3:0] st, input logic u, input logic wr);
    cpuAddrIn <= va;
    cycleStatusCode <= st;
    userMode <= u;
    dataDirectionNIn <= wr;
    cycleReq <= 1'b1;
    @(posedge ref_clk);
    cycleReq <= 1'b0;
    nValid = 0;
    nAbort = 0;
    nFloat = 0;
    nStrobe = 0;
    nUpper = 0;
    repeat (20 * TICK) begin
      @(posedge ref_clk);
      if (physAddrValidN === 1'b0 && physAddrOeN === 1'b0) begin nValid++; paSeen = physAddr; end
      if (cpuResetAbortN === 1'b0) nAbort++;
      if (busFloatRequestN === 1'b0) begin nFloat++; fltSeen = {dataDirectionOeN, dataDirectionNOut, physAddr}; end
      if (busStrobeN === 1'b0) nStrobe++;
      if (upperBufEnN === 1'b0) nUpper++;
    end
  endtask

  initial begin
    rst = 1'b1;
    busWidthSelect = 1'b1;
    userMode = 1'b0;
    dataDirectionNIn = 1'b0;
    translateModeSlaveStrobeNIn = 1'b1;
    cpuAddrIn = 24'h0;
    cycleStatusCode = 4'h0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    resetReq = 1'b0;
    cycleReq = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    k = 0;
    while ((resetInN !== 1'b1 || translateModeSlaveStrobeOeN !== 1'b1) && k < 1000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 1000) n_errors++;
    // let the translate strobe hold run out before the first processor cycle
    repeat (6 * TICK) @(posedge ref_clk);
    // entry 0 supervisor page, entry 1 user page, both level 2 and modified
    bus(1'b1, REG_TLB_SEL, 32'h0);
    bus(1'b1, REG_TLB_TAG, 32'h0001_1234);
    bus(1'b1, REG_TLB_DATA, 32'h0006_0155);
    bus(1'b1, REG_TLB_SEL, 32'h1);
    bus(1'b1, REG_TLB_TAG, 32'h0001_8321);
    bus(1'b1, REG_TLB_DATA, 32'h0006_00AA);
    bus(1'b1, REG_CTRL, 32'h0000_3400);
    cyc(24'hABCDEF, ST_DATA, 1'b0, 1'b0);
    check(nValid, TICK);
    check(paSeen, {1'b0, 24'hABCDEF});
    check(nStrobe, TICK);
    resetTest(1'b0);
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0000_3400);
    bus(1'b1, REG_CTRL, 32'h0000_3401);
    cyc(24'h2468A5, ST_DATA, 1'b0, 1'b0);
    check(paSeen, {16'h0155, 9'h0A5});
    for (int i = 0; i < 6; i++) begin
      cyc(24'h0643FF, okCodes[i], 1'b1, 1'b0);
      check(nValid, TICK);
      check(nAbort, 0);
      check(paSeen, {16'h00AA, 9'h1FF});
    end
    // read-modify-write read on a user read-only page aborts
    cyc(24'h0643FF, ST_RMW, 1'b1, 1'b0);
    check(nValid, 0);
    check(nAbort, TICK);
    cyc(24'h0643FF, ST_DATA, 1'b1, 1'b1);
    check(nValid, 0);
    check(nAbort, TICK);
    // user space has no entry for this page: bus seized, then abort
    cyc(24'h2468A5, ST_DATA, 1'b1, 1'b0);
    check(nFloat, 2 * TICK);
    check(nAbort, TICK);
    check(nValid, 0);
    check(fltSeen, {1'b0, 1'b0, 8'h34, 15'h1234, 2'b00});
    check(nUpper, 0);
    cyc(24'h2468A5, ST_DATA, 1'b0, 1'b1);
    check(nValid, TICK);
    // user write to a clean level-3 page: bus seized, modified bit set, then valid
    bus(1'b1, REG_TLB_DATA, 32'h0003_00AA);
    cyc(24'h0643FF, ST_DATA, 1'b1, 1'b1);
    check(nFloat, 2 * TICK);
    check(fltSeen, {1'b0, 1'b1, 8'h34, 15'h0321, 2'b00});
    check(nValid, TICK);
    check(paSeen, {16'h00AA, 9'h1FF});
    bus(1'b0, REG_TLB_DATA, 32'h0);
    check(rd, 32'h0007_00AA);
    // slave code with slave strobe, outside translation
    cycleStatusCode <= ST_SLV_ID;
    translateModeSlaveStrobeNIn <= 1'b0;
    repeat (TICK) @(posedge ref_clk);
    translateModeSlaveStrobeNIn <= 1'b1;
    repeat (2 * TICK) @(posedge ref_clk);
    bus(1'b0, REG_MSR, 32'h0);
    check(rd[MSR_SLAVE], 1'b1);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    check(rd, 32'h0);
    resetTest(1'b1);
    stop_test();
  end

  // watchdog
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
